// ===== gcfd_field_decode.sv
// Purpose: decode soft run, standard, channel, gain and sync offsets
// Assumes: clock_i is the double-rate clock; shift port is asynchronous
// Notes:   outputs come from flip-flops; output enable and pixel clock gated by the soft run bit
`timescale 1ns/100ps
`default_nettype none
// Contract
// - run bit low: hold state machines, keep written word, outputs off
// - run bit high: run state machines, pixel clock and outputs
// - standard code 000, 001, 100 select formats; others reserved
// - channel 00 input one, 01 input two, 1x input three
// - gain bit low unity, high one and a half
// - fine phase is signed five bits, thirty-second pixel steps
// - fine phase zero no shift; 18h delays, 08h advances quarter
// - coarse offset eight bits, minus 123 to plus 132 cycles
// - coarse 7Bh aligns; each step above delays, below advances
// - shifted word becomes active on third clock after transfer rises
module gcfd_field_decode (
	input  wire logic                     clock_i,
	input  wire logic                     rst_n_i,
	input  wire logic                     transfer_i,
	input  wire logic [gcfd_pkg::CTRL_W-1:0] shift_word_i,
	output var gcfd_pkg::gcfd_cfg_t       cfg_o,
	output logic                          run_o,
	output logic                          out_enable_o,
	output logic                          pixel_rate_clock_o,
	output logic                          std_reserved_o,
	output logic [gcfd_pkg::CTRL_W-1:0]   active_word_o
);
	// ---------------------------------------------------------------
	// transfer edge capture
	// ---------------------------------------------------------------
	logic                          xfer_s1_r;
	logic                          xfer_s2_r;
	logic                          xfer_d_r;
	logic [gcfd_pkg::CTRL_W-1:0]   word_s1_r;
	logic [gcfd_pkg::CTRL_W-1:0]   word_s2_r;
	logic                          load;
	logic [gcfd_pkg::CTRL_W-1:0]   word;
	logic                          pix_div_r;
	gcfd_pkg::gcfd_cfg_t           cfg_nxt;

	// transfer is a pin-side level: two-flop synchroniser
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			xfer_s1_r <= 1'b0;
			xfer_s2_r <= 1'b0;
			xfer_d_r  <= 1'b0;
		end else begin
			xfer_s1_r <= transfer_i;
			xfer_s2_r <= xfer_s1_r;
			xfer_d_r  <= xfer_s2_r;
		end
	end

	// shift word also comes from the port side: two flops before use
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_s1_r <= '0;
			word_s2_r <= '0;
		end else begin
			word_s1_r <= shift_word_i;
			word_s2_r <= word_s1_r;
		end
	end

	// start (rising edge) of the synchronised transfer command loads the word
	assign load = xfer_s2_r & ~xfer_d_r;

	// ---------------------------------------------------------------
	// active word
	// ---------------------------------------------------------------
	// the store keeps the last written word while run is low
	gcfd_word_store #(
		.W(gcfd_pkg::CTRL_W)
	) u_store (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.load_i  (load),
		.data_i  (word_s2_r),
		.word_o  (word)
	);

	assign active_word_o = word;

	// ---------------------------------------------------------------
	// field decode
	// ---------------------------------------------------------------
	function automatic gcfd_pkg::gcfd_std_t dec_std(input logic [2:0] c);
		case (c)
			gcfd_pkg::STD_NTSC_1227: dec_std = gcfd_pkg::GCFD_STD_N1227;
			gcfd_pkg::STD_NTSC_135:  dec_std = gcfd_pkg::GCFD_STD_N135;
			gcfd_pkg::STD_PAL_135:   dec_std = gcfd_pkg::GCFD_STD_P135;
			default:                 dec_std = gcfd_pkg::GCFD_STD_RSVD;
		endcase
	endfunction : dec_std

	function automatic gcfd_pkg::gcfd_chan_t dec_chan(input logic [1:0] c);
		case (c)
			2'h0:    dec_chan = gcfd_pkg::GCFD_IN_ONE;
			2'h1:    dec_chan = gcfd_pkg::GCFD_IN_TWO;
			default: dec_chan = gcfd_pkg::GCFD_IN_THREE;
		endcase
	endfunction : dec_chan

	// combinational decode of the active word
	always_comb begin
		cfg_nxt.run = word[gcfd_pkg::RUN_POS];
		cfg_nxt.std = dec_std(
			word[gcfd_pkg::STD_LSB +: gcfd_pkg::STD_W]);
		cfg_nxt.chan = dec_chan(
			word[gcfd_pkg::SRC_LSB +: gcfd_pkg::SRC_W]);
		cfg_nxt.gain_boost = word[gcfd_pkg::GAIN_POS];
		cfg_nxt.fine_phase_offset =
			word[gcfd_pkg::FINE_LSB +: gcfd_pkg::FINE_W];
		// signed offset in pixel cycles: code minus the align code
		cfg_nxt.coarse_line_offset = 9'(
			{1'b0, word[gcfd_pkg::COARSE_LSB +: gcfd_pkg::COARSE_W]}
			- {1'b0, gcfd_pkg::COARSE_ALIGN});
		cfg_nxt.test_bits_set =
			(|word[gcfd_pkg::TEST_A_LSB +: gcfd_pkg::TEST_A_W]) |
			(|word[gcfd_pkg::TEST_B_LSB +: gcfd_pkg::TEST_B_W]);
	end

	// registered settings, decoded from the active word
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_o <= '0;
			cfg_o.coarse_line_offset <= 9'h000;
		end else begin
			cfg_o <= cfg_nxt;
		end
	end

	// ---------------------------------------------------------------
	// run control and pixel-rate clock
	// ---------------------------------------------------------------
	// run and output enable follow the soft run bit
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_o          <= 1'b0;
			out_enable_o   <= 1'b0;
			std_reserved_o <= 1'b0;
		end else begin
			run_o          <= cfg_nxt.run;
			out_enable_o   <= cfg_nxt.run;
			std_reserved_o <= cfg_nxt.std == gcfd_pkg::GCFD_STD_RSVD;
		end
	end

	// half-rate divider, stopped and cleared while run is low
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pix_div_r <= 1'b0;
		end else if (!cfg_nxt.run) begin
			pix_div_r <= 1'b0;
		end else begin
			pix_div_r <= ~pix_div_r;
		end
	end

	assign pixel_rate_clock_o = pix_div_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	sequence s_xfer_rise;
		xfer_s2_r && !xfer_d_r;
	endsequence

	property p_load;
		@(posedge clock_i) disable iff (!rst_n_i)
		s_xfer_rise |=> (active_word_o == $past(shift_word_i));
	endproperty
	a_load: assert property (p_load)
		else $error("word not loaded after transfer");

	property p_hold;
		@(posedge clock_i) disable iff (!rst_n_i)
		!xfer_s2_r |=> $stable(active_word_o) || $past(load);
	endproperty
	a_hold: assert property (p_hold)
		else $error("word changed without transfer");

	property p_run_off;
		@(posedge clock_i) disable iff (!rst_n_i)
		!active_word_o[0] |=> !out_enable_o && !pixel_rate_clock_o;
	endproperty
	a_run_off: assert property (p_run_off)
		else $error("outputs active while run low");

	property p_run_on;
		@(posedge clock_i) disable iff (!rst_n_i)
		active_word_o[0] [*3] |-> out_enable_o
			&& (pixel_rate_clock_o != $past(pixel_rate_clock_o));
	endproperty
	a_run_on: assert property (p_run_on)
		else $error("outputs or clock idle while run high");

	property p_std;
		@(posedge clock_i) disable iff (!rst_n_i)
		(active_word_o[3:1] == 3'h4) |=>
			cfg_o.std == gcfd_pkg::GCFD_STD_P135;
	endproperty
	a_std: assert property (p_std)
		else $error("standard code 100 misdecoded");

	property p_chan;
		@(posedge clock_i) disable iff (!rst_n_i)
		active_word_o[8] |=> cfg_o.chan == gcfd_pkg::GCFD_IN_THREE;
	endproperty
	a_chan: assert property (p_chan)
		else $error("channel msb not input three");

	property p_gain;
		@(posedge clock_i) disable iff (!rst_n_i)
		1'b1 |=> cfg_o.gain_boost == $past(active_word_o[9]);
	endproperty
	a_gain: assert property (p_gain)
		else $error("gain bit misdecoded");

	property p_fine;
		@(posedge clock_i) disable iff (!rst_n_i)
		(active_word_o[16:12] == 5'h18) |=>
			cfg_o.fine_phase_offset == 5'sh18;
	endproperty
	a_fine: assert property (p_fine)
		else $error("fine phase 18h not minus eight");

	property p_coarse;
		@(posedge clock_i) disable iff (!rst_n_i)
		(active_word_o[24:17] == 8'h83) |=>
			cfg_o.coarse_line_offset == 9'sh008;
	endproperty
	a_coarse: assert property (p_coarse)
		else $error("coarse 83h not plus eight");
endmodule : gcfd_field_decode
`default_nettype wire

// ===== gcfd_pkg.sv
// Purpose: constants and carrier types for the control field decoder
// Assumes: low 25 bits of the control word are decoded here
// Notes:   field positions and reset values are defined in this package
package gcfd_pkg;

	// ---------------------------------------------------------------
	// word layout
	// ---------------------------------------------------------------
	localparam int          CTRL_W        = 47;
	localparam int          RUN_POS       = 0;
	localparam int          STD_LSB       = 1;
	localparam int          STD_W         = 3;
	localparam int          TEST_A_LSB    = 4;
	localparam int          TEST_A_W      = 3;
	localparam int          SRC_LSB       = 7;
	localparam int          SRC_W         = 2;
	localparam int          GAIN_POS      = 9;
	localparam int          TEST_B_LSB    = 10;
	localparam int          TEST_B_W      = 2;
	localparam int          FINE_LSB      = 12;
	localparam int          FINE_W        = 5;
	localparam int          COARSE_LSB    = 17;
	localparam int          COARSE_W      = 8;

	// ---------------------------------------------------------------
	// codes and values after reset
	// ---------------------------------------------------------------
	localparam logic [2:0]  STD_NTSC_1227 = 3'h0;
	localparam logic [2:0]  STD_NTSC_135  = 3'h1;
	localparam logic [2:0]  STD_PAL_135   = 3'h4;
	localparam logic [7:0]  COARSE_ALIGN  = 8'h7B;
	localparam logic [46:0] CTRL_RST      = 47'h0000_0000_0000;
	localparam logic [7:0]  COARSE_RST    = 8'h7B;

	typedef enum logic [1:0] {
		GCFD_STD_N1227 = 2'h0,
		GCFD_STD_N135  = 2'h1,
		GCFD_STD_P135  = 2'h2,
		GCFD_STD_RSVD  = 2'h3
	} gcfd_std_t;

	typedef enum logic [1:0] {
		GCFD_IN_ONE   = 2'h0,
		GCFD_IN_TWO   = 2'h1,
		GCFD_IN_THREE = 2'h2
	} gcfd_chan_t;

	// decoded settings handed to the datapath
	typedef struct packed {
		logic             run;
		gcfd_std_t        std;
		gcfd_chan_t       chan;
		logic             gain_boost;
		logic signed [4:0] fine_phase_offset;
		logic signed [8:0] coarse_line_offset;
		logic             test_bits_set;
	} gcfd_cfg_t;

endpackage : gcfd_pkg

// ===== gcfd_word_store.sv
// Purpose: holds the active control word, loaded on a one-cycle strobe
// Assumes: load strobe comes from the same clock domain
// Notes:   without a load the last word written is kept
`timescale 1ns/100ps
`default_nettype none
module gcfd_word_store #(
	parameter int W = gcfd_pkg::CTRL_W
) (
	input  wire logic         clock_i,
	input  wire logic         rst_n_i,
	input  wire logic         load_i,
	input  wire logic [W-1:0] data_i,
	output logic      [W-1:0] word_o
);
	initial begin
		if (W < 25) begin
			$error("gcfd_word_store: word too narrow");
		end
	end

	// active word register
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			word_o <= W'(gcfd_pkg::CTRL_RST);
		end else if (load_i) begin
			word_o <= data_i;
		end
	end
endmodule : gcfd_word_store
`default_nettype wire

// ===== gcfd_host_model.sv
// Purpose: host side of the shift port, loads control words with the test bits cleared
// Assumes: requests change 1 ns after a rising clock edge
// Notes:   word is garbled once its hold time has run out
`timescale 1ns/100ps
`default_nettype none
module gcfd_host_model (
	input  wire logic        clock_i,
	output logic             transfer_o,
	output logic [46:0]      word_o
);
	initial begin
		transfer_o = 1'b0;
		word_o     = 47'h0;
	end
	// -------------------------------------------------------------
	// one full transfer, then the low gap before the next
	// -------------------------------------------------------------
	task automatic load(input logic [46:0] w);
		@(posedge clock_i);
		#1;
		word_o     = w & ~47'h0000_0000_0C70;
		transfer_o = 1'b1;
		repeat (3) @(posedge clock_i);
		#1;
		word_o     = ~word_o; // stale data no longer valid
		transfer_o = 1'b0;
		repeat (3) @(posedge clock_i);
	endtask : load
endmodule : gcfd_host_model
`default_nettype wire

// ===== genlock_control_field_decode_test.sv
// Purpose: loads control words and checks the decoded settings
// Assumes: outputs settled a few cycles after each transfer
// Notes:   expectations built from field positions and codes
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin \
	num_errors++; $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module genlock_control_field_decode_test;
	logic                clock_i;
	logic                rst_n_i;
	logic                transfer;
	logic [46:0]         word;
	logic [46:0]         act;
	gcfd_pkg::gcfd_cfg_t cfg;
	logic                run;
	logic                oe;
	logic                pclk;
	logic                rsvd;
	int                  num_errors;
	int                  n_compared;

	gcfd_host_model host (.clock_i(clock_i), .transfer_o(transfer),
		.word_o(word));
	gcfd_field_decode dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.transfer_i(transfer), .shift_word_i(word), .cfg_o(cfg),
		.run_o(run), .out_enable_o(oe), .pixel_rate_clock_o(pclk),
		.std_reserved_o(rsvd), .active_word_o(act));

	initial begin
		clock_i = 1'b0;
		forever #2.5 clock_i = ~clock_i;
	end

	// -------------------------------------------------------------
	// verdict and end of run
	// -------------------------------------------------------------
	task automatic complete_run();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : complete_run

	// -------------------------------------------------------------
	// load one word; check every decoded field when the run bit is set
	// -------------------------------------------------------------
	task automatic scen(input logic r, input logic [2:0] s,
		input logic [1:0] c, input logic g, input logic [4:0] f,
		input logic [7:0] k);
		logic [46:0]          w;
		gcfd_pkg::gcfd_std_t  es;
		gcfd_pkg::gcfd_chan_t ec;
		logic signed [8:0]    ek;
		logic                 p;
		w  = {22'h0, k, f, 2'h0, g, c, 3'h0, s, r};
		es = (s == 3'h0) ? gcfd_pkg::GCFD_STD_N1227 :
			(s == 3'h1) ? gcfd_pkg::GCFD_STD_N135 :
			(s == 3'h4) ? gcfd_pkg::GCFD_STD_P135 :
			gcfd_pkg::GCFD_STD_RSVD;
		ec = c[1] ? gcfd_pkg::GCFD_IN_THREE :
			(c[0] ? gcfd_pkg::GCFD_IN_TWO : gcfd_pkg::GCFD_IN_ONE);
		ek = {1'b0, k} - 9'h07B;
		host.load(w);
		#1;
		`CHK("word", w, act)
		`CHK("test", 1'b0, cfg.test_bits_set)
		`CHK("run", r, run)
		`CHK("oe", r, oe)
		if (r) begin
			`CHK("std", es, cfg.std)
			`CHK("rsvd", es == gcfd_pkg::GCFD_STD_RSVD, rsvd)
			`CHK("chan", ec, cfg.chan)
			`CHK("gain", g, cfg.gain_boost)
			`CHK("fine", f, cfg.fine_phase_offset)
			`CHK("coarse", ek, cfg.coarse_line_offset)
		end
		p = pclk;
		@(posedge clock_i);
		#1;
		`CHK("pclk", r ? ~p : 1'b0, pclk)
	endtask : scen

	// -------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------
	initial begin
		num_errors = 0;
		n_compared = 0;
		rst_n_i    = 1'b0;
		repeat (4) @(posedge clock_i);
		#1;
		rst_n_i = 1'b1;
		`CHK("run0", 1'b0, run)
		scen(1'b1, 3'h0, 2'h0, 1'b0, 5'h00, 8'h7B);
		scen(1'b1, 3'h1, 2'h1, 1'b1, 5'h18, 8'h83);
		scen(1'b1, 3'h4, 2'h2, 1'b0, 5'h08, 8'h73);
		// reserved codes 2, 7, 3 and 5 below check the reserved flag along with every other field; the last word has run low
		scen(1'b1, 3'h2, 2'h3, 1'b1, 5'h10, 8'h01);
		scen(1'b1, 3'h7, 2'h3, 1'b0, 5'h0F, 8'hFF);
		scen(1'b1, 3'h3, 2'h0, 1'b0, 5'h00, 8'h7B);
		scen(1'b1, 3'h5, 2'h1, 1'b0, 5'h00, 8'h7B);
		scen(1'b0, 3'h1, 2'h1, 1'b1, 5'h18, 8'h83);
		complete_run();
	end

	// watchdog against a hung run
	initial begin
		#20000;
		num_errors++;
		complete_run();
	end
endmodule : genlock_control_field_decode_test
`default_nettype wire
